// >>> apc_axis_position_control.sv
`timescale 1ns/10ps
module apc_axis_position_control import apc_pkg::*; (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic home_z_input_i,
	input wire logic enc_a_i,
	input wire logic enc_b_i,
	output logic pulse_plus_o,
	output logic pulse_minus_o,
	output logic driving_o
);
	// bus write and read handshake
	logic aw_hold_q, w_hold_q, bvalid_q;
	logic [ADDR_WIDTH-1:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	wire aw_fire = s_axi_awvalid && s_axi_awready;
	wire w_fire = s_axi_wvalid && s_axi_wready;
	wire ar_fire = s_axi_arvalid && s_axi_arready;
	wire wr_go = ce_i && aw_hold_q && w_hold_q && !bvalid_q;
	wire [7:0] wa = {aw_addr_q[7:2], 2'b00};
	wire [7:0] ra = {s_axi_araddr[7:2], 2'b00};
	wire [31:0] wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
	assign s_axi_awready = ce_i && !aw_hold_q;
	assign s_axi_wready = ce_i && !w_hold_q;
	assign s_axi_arready = ce_i && !rvalid_q;
	assign s_axi_bvalid = ce_i && bvalid_q;
	assign s_axi_rvalid = ce_i && rvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	function automatic logic [31:0] merge(input logic [31:0] old);
		merge = (old & ~wmask) | (w_data_q & wmask);
	endfunction

	// software registers
	logic [31:0] wr1_q, wr2_q, wr3_q, upper_cmp_q, lower_cmp_q;
	logic [15:0] per_int_q, per_frac_q;
	apc_cfg_type cfg;
	assign cfg.ring = wr3_q[WR3_RING_BIT];
	assign cfg.phase = wr3_q[WR3_PHASE_LSB +: 2];
	assign cfg.enc_updown = wr2_q[WR2_ENC_UPDOWN_BIT];
	assign cfg.cmp_sel = wr2_q[WR2_CMP_SEL_BIT];
	assign cfg.slim_low = wr2_q[WR2_SLIM_LOW_BIT];
	assign cfg.slim_up = wr2_q[WR2_SLIM_UP_BIT];
	assign cfg.z_clr = wr1_q[WR1_Z_CLR_BIT];
	assign cfg.z_en = wr1_q[WR1_Z_EN_BIT];
	assign cfg.z_level = wr1_q[WR1_Z_LEVEL_BIT];

	wire wr_cmd = wr_go && wa == OFF_CMD && w_strb_q[0];
	wire cmd_plus = wr_cmd && w_data_q[CMD_PLUS_BIT];
	wire cmd_minus = wr_cmd && w_data_q[CMD_MINUS_BIT] && !w_data_q[CMD_PLUS_BIT];
	wire cmd_decel = wr_cmd && w_data_q[CMD_DECEL_BIT];
	wire cmd_halt = wr_cmd && w_data_q[CMD_HALT_BIT];
	wire lc_load = wr_go && wa == OFF_LOGICAL;
	wire rc_load = wr_go && wa == OFF_REAL;
	wire [31:0] per_int_m = merge({16'h0000, per_int_q});
	wire [31:0] per_frac_m = merge({16'h0000, per_frac_q});
	wire wr_mapped = wa == OFF_CMD || wa == OFF_WR1 || wa == OFF_WR2 || wa == OFF_WR3 ||
		wa == OFF_PER_INT || wa == OFF_PER_FRAC || wa == OFF_LOGICAL || wa == OFF_REAL ||
		wa == OFF_UPPER || wa == OFF_LOWER || wa == OFF_STAT1 || wa == OFF_ERR;
	wire rd_mapped = ra == OFF_CMD || ra == OFF_WR1 || ra == OFF_WR2 || ra == OFF_WR3 ||
		ra == OFF_PER_INT || ra == OFF_PER_FRAC || ra == OFF_LOGICAL || ra == OFF_REAL ||
		ra == OFF_UPPER || ra == OFF_LOWER || ra == OFF_STAT1 || ra == OFF_ERR;

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			aw_hold_q <= 1'b0;
			aw_addr_q <= '0;
		end else if (ce_i) begin
			if (aw_fire) begin
				aw_hold_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_hold_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			w_hold_q <= 1'b0;
			w_data_q <= '0;
			w_strb_q <= '0;
		end else if (ce_i) begin
			if (w_fire) begin
				w_hold_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end else if (wr_go) begin
				w_hold_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else if (ce_i) begin
			if (wr_go) begin
				bvalid_q <= 1'b1;
				bresp_q <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			wr1_q <= WR_RST;
			wr2_q <= WR_RST;
			wr3_q <= WR_RST;
			per_int_q <= PER_INT_RST;
			per_frac_q <= PER_FRAC_RST;
		end else if (wr_go) begin
			if (wa == OFF_WR1) wr1_q <= merge(wr1_q) & WR1_MASK;
			if (wa == OFF_WR2) wr2_q <= merge(wr2_q) & WR2_MASK;
			if (wa == OFF_WR3) wr3_q <= merge(wr3_q) & WR3_MASK;
			if (wa == OFF_PER_INT) per_int_q <= per_int_m[15:0];
			if (wa == OFF_PER_FRAC) per_frac_q <= per_frac_m[15:0];
		end
	end

	// compare values are written at any time, also while driving
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			upper_cmp_q <= CNT_RST;
			lower_cmp_q <= CNT_RST;
		end else if (wr_go) begin
			if (wa == OFF_UPPER) upper_cmp_q <= merge(upper_cmp_q);
			if (wa == OFF_LOWER) lower_cmp_q <= merge(lower_cmp_q);
		end
	end

	// internal tick at half the clock
	logic tick_q;
	wire act = ce_i && tick_q;
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) tick_q <= 1'b0;
		else if (ce_i) tick_q <= !tick_q;
	end

	// home input and encoder decode
	logic z_arm_q, enc_a_q, enc_b_q;
	wire z_active = cfg.z_en && (cfg.z_level ? home_z_input_i : !home_z_input_i);
	wire z_arm = z_active && cfg.z_clr;
	wire real_clear = z_arm && !z_arm_q;
	wire enc_chg = enc_a_i ^ enc_a_q ^ enc_b_i ^ enc_b_q;
	wire enc_inc = cfg.enc_updown ? (enc_a_i && !enc_a_q) : (enc_chg && (enc_b_q ^ enc_a_i));
	wire enc_dec = cfg.enc_updown ? (enc_b_i && !enc_b_q) : (enc_chg && !(enc_b_q ^ enc_a_i));
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			z_arm_q <= 1'b0;
			enc_a_q <= 1'b0;
			enc_b_q <= 1'b0;
		end else if (ce_i) begin
			z_arm_q <= z_arm;
			enc_a_q <= enc_a_i;
			enc_b_q <= enc_b_i;
		end
	end

	// position counters
	apc_state_type state_q, state_d;
	logic level_q, level_d, dir_minus_q, plus_q, minus_q, stop_pend_q;
	logic [31:0] lc_count, rc_count;
	wire pulse_start = level_d && !level_q;
	apc_ring_counter #(.WIDTH(CNT_WIDTH)) u_logical (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.ce_i(ce_i),
		.load_i(lc_load),
		.load_val_i(merge(lc_count)),
		.clear_i(1'b0),
		.inc_i(pulse_start && !dir_minus_q),
		.dec_i(pulse_start && dir_minus_q),
		.ring_en_i(cfg.ring),
		.ring_max_i(upper_cmp_q),
		.count_o(lc_count)
	);
	apc_ring_counter #(.WIDTH(CNT_WIDTH)) u_real (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.ce_i(ce_i),
		.load_i(rc_load),
		.load_val_i(merge(rc_count)),
		.clear_i(real_clear),
		.inc_i(enc_inc),
		.dec_i(enc_dec),
		.ring_en_i(cfg.ring),
		.ring_max_i(lower_cmp_q),
		.count_o(rc_count)
	);

	// compares and soft limits
	logic up_flag_q, low_flag_q, up_err_q, low_err_q;
	wire [31:0] sel_cnt = cfg.cmp_sel ? rc_count : lc_count;
	wire exceed_up = $signed(sel_cnt) > $signed(upper_cmp_q);
	wire below_low = $signed(sel_cnt) < $signed(lower_cmp_q);
	wire driving = state_q != S_IDLE;
	wire sl_stop = driving && ((up_err_q && !dir_minus_q) || (low_err_q && dir_minus_q));
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			up_flag_q <= 1'b0;
			low_flag_q <= 1'b0;
			up_err_q <= 1'b0;
			low_err_q <= 1'b0;
		end else if (ce_i) begin
			up_flag_q <= exceed_up;
			low_flag_q <= below_low;
			up_err_q <= cfg.slim_up && !cfg.ring && exceed_up;
			low_err_q <= cfg.slim_low && !cfg.ring && below_low;
		end
	end

	// pulse period with fractional mixing
	logic [15:0] acc_q;
	logic [16:0] cnt_q, cnt_d, period_q, high_q, low_q;
	logic [1:0] phase_q;
	wire [16:0] acc_sum = {1'b0, acc_q} + {1'b0, per_frac_q};
	wire [16:0] int_eff = ({1'b0, per_int_q} < PERIOD_MIN) ? PERIOD_MIN : {1'b0, per_int_q};
	wire [16:0] per_next = int_eff + {16'h0000, acc_sum[16]};
	wire [16:0] quarter = per_next >> 2;
	wire [1:0] phase_eff = cfg.z_en ? PHASE_CONST : cfg.phase;
	wire [16:0] high_next = (phase_eff == PHASE_ACCEL) ? per_next - quarter :
		(phase_eff == PHASE_DECEL) ? quarter : per_next >> 1;
	wire [16:0] low_next = per_next - high_next;
	wire halt = cmd_halt || (z_active && driving);
	wire start = state_q == S_IDLE && (cmd_plus || cmd_minus);

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		level_d = level_q;
		case (state_q)
			S_IDLE: begin
				if (start) state_d = S_LOAD;
			end
			S_LOAD: begin
				if (act) begin
					if (stop_pend_q || sl_stop) begin
						state_d = S_IDLE;
					end else begin
						state_d = S_HIGH;
						cnt_d = high_next - 17'h00001;
						level_d = 1'b1;
					end
				end
			end
			S_HIGH: begin
				if (act) begin
					if (cnt_q == '0) begin
						state_d = S_LOW;
						cnt_d = low_q - 17'h00001;
						level_d = 1'b0;
					end else begin
						cnt_d = cnt_q - 17'h00001;
					end
				end
			end
			S_LOW: begin
				if (act) begin
					if (cnt_q != '0) begin
						cnt_d = cnt_q - 17'h00001;
					end else if (stop_pend_q || sl_stop) begin
						state_d = S_IDLE;
					end else begin
						state_d = S_HIGH;
						cnt_d = high_next - 17'h00001;
						level_d = 1'b1;
					end
				end
			end
			default: begin
				state_d = S_IDLE;
			end
		endcase
		if (halt) begin
			state_d = S_IDLE;
			level_d = 1'b0;
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_q <= S_IDLE;
			cnt_q <= '0;
			level_q <= 1'b0;
			dir_minus_q <= 1'b0;
			plus_q <= 1'b0;
			minus_q <= 1'b0;
		end else if (ce_i) begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			level_q <= level_d;
			if (start) dir_minus_q <= cmd_minus;
			plus_q <= level_d && !dir_minus_q;
			minus_q <= level_d && dir_minus_q;
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			stop_pend_q <= 1'b0;
			acc_q <= '0;
			period_q <= PERIOD_MIN;
			high_q <= '0;
			low_q <= '0;
			phase_q <= PHASE_CONST;
		end else if (ce_i) begin
			if (state_d == S_IDLE) stop_pend_q <= 1'b0;
			else if (driving && (cmd_decel || sl_stop)) stop_pend_q <= 1'b1;
			if (pulse_start) begin
				acc_q <= acc_sum[15:0];
				period_q <= per_next;
				high_q <= high_next;
				low_q <= low_next;
				phase_q <= phase_eff;
			end
		end
	end

	assign pulse_plus_o = plus_q;
	assign pulse_minus_o = minus_q;
	assign driving_o = driving;

	// read side
	wire [31:0] rd_data = (ra == OFF_CMD) ? {29'h0, stop_pend_q, dir_minus_q, driving} :
		(ra == OFF_WR1) ? wr1_q : (ra == OFF_WR2) ? wr2_q : (ra == OFF_WR3) ? wr3_q :
		(ra == OFF_PER_INT) ? {16'h0000, per_int_q} : (ra == OFF_PER_FRAC) ? {16'h0000, per_frac_q} :
		(ra == OFF_LOGICAL) ? lc_count : (ra == OFF_REAL) ? rc_count :
		(ra == OFF_UPPER) ? upper_cmp_q : (ra == OFF_LOWER) ? lower_cmp_q :
		(ra == OFF_STAT1) ? {30'h0, low_flag_q, up_flag_q} :
		(ra == OFF_ERR) ? {30'h0, low_err_q, up_err_q} : 32'h0000_0000;
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= RESP_OKAY;
		end else if (ce_i) begin
			if (ar_fire) begin
				rvalid_q <= 1'b1;
				rdata_q <= rd_data;
				rresp_q <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	property p_period_split;
		@(posedge clk_i) disable iff (reset_i)
		(state_q == S_HIGH || state_q == S_LOW) |-> (high_q + low_q == period_q && period_q >= PERIOD_MIN);
	endproperty
	a_period_split: assert property (p_period_split) else $error("pulse halves do not sum to period");
	property p_const_duty;
		@(posedge clk_i) disable iff (reset_i)
		(state_q == S_HIGH && phase_q == PHASE_CONST) |-> (low_q == high_q || low_q == high_q + 17'h00001);
	endproperty
	a_const_duty: assert property (p_const_duty) else $error("constant speed duty not even");
	property p_ramp_shape;
		@(posedge clk_i) disable iff (reset_i)
		(state_q == S_HIGH || state_q == S_LOW) |->
			((phase_q != PHASE_ACCEL || low_q < high_q) && (phase_q != PHASE_DECEL || low_q > high_q));
	endproperty
	a_ramp_shape: assert property (p_ramp_shape) else $error("ramp duty shape wrong");
	property p_tick_edges;
		@(posedge clk_i) disable iff (reset_i)
		$rose(level_q) |-> $past(tick_q) && $past(ce_i) && !tick_q;
	endproperty
	a_tick_edges: assert property (p_tick_edges) else $error("pulse edge off the internal tick");
	property p_frac_mix;
		@(posedge clk_i) disable iff (reset_i)
		$rose(level_q) |-> (period_q == $past(int_eff) || period_q == $past(int_eff) + 17'h00001);
	endproperty
	a_frac_mix: assert property (p_frac_mix) else $error("period not adjacent to integer setting");
	property p_logical_inc;
		@(posedge clk_i) disable iff (reset_i)
		(ce_i && pulse_start && !dir_minus_q && !lc_load && !cfg.ring) |=> lc_count == $past(lc_count) + 32'h1;
	endproperty
	a_logical_inc: assert property (p_logical_inc) else $error("logical counter missed a plus pulse");
	property p_upper_flag;
		@(posedge clk_i) disable iff (reset_i)
		ce_i |=> up_flag_q == ($signed($past(cfg.cmp_sel ? rc_count : lc_count)) > $signed($past(upper_cmp_q)));
	endproperty
	a_upper_flag: assert property (p_upper_flag) else $error("upper compare flag wrong");
	property p_lower_flag;
		@(posedge clk_i) disable iff (reset_i)
		(ce_i && $signed(cfg.cmp_sel ? rc_count : lc_count) >= $signed(lower_cmp_q)) |=> !low_flag_q;
	endproperty
	a_lower_flag: assert property (p_lower_flag) else $error("lower compare flag stuck");
	property p_soft_stop;
		@(posedge clk_i) disable iff (reset_i)
		(state_q == S_LOW && act && cnt_q == '0 && sl_stop && !halt) |=> (state_q == S_IDLE && !plus_q && !minus_q);
	endproperty
	a_soft_stop: assert property (p_soft_stop) else $error("soft limit did not stop drive");
	property p_soft_auto;
		@(posedge clk_i) disable iff (reset_i)
		(ce_i && $signed(cfg.cmp_sel ? rc_count : lc_count) <= $signed(upper_cmp_q)) |=> !up_err_q;
	endproperty
	a_soft_auto: assert property (p_soft_auto) else $error("upper limit error did not clear");
	property p_home_clear;
		@(posedge clk_i) disable iff (reset_i)
		(ce_i && real_clear && !rc_load) |=> rc_count == 32'h0000_0000;
	endproperty
	a_home_clear: assert property (p_home_clear) else $error("real counter not cleared on home onset");
	property p_home_halt;
		@(posedge clk_i) disable iff (reset_i)
		(ce_i && z_active && driving) |=> (state_q == S_IDLE && !plus_q && !minus_q);
	endproperty
	a_home_halt: assert property (p_home_halt) else $error("home detection did not halt pulses");
endmodule

// >>> apc_pkg.sv
// Operation
// - pulse period accurate to one internal tick
// - constant speed pulses have equal halves, low half one tick longer on odd periods
// - with home input disabled, accel shortens low part, decel lengthens
// - internal tick is input clock halved
// - mix adjacent periods for fractional speeds
// - logical counter follows output pulse direction
// - real counter takes quadrature or up/down
// - counters signed 32-bit, host read/write
// - source select picks counter for compares
// - upper flag while counter above upper compare
// - lower flag while counter below lower compare
// - outside ring mode, upper soft limit stops plus drive, sets error
// - upper soft limit error clears by itself
// - compare registers writable at any time
// - plain mode wraps across full 32 bits
// - ring mode wraps at compare maxima
// - one ring bit serves both counters
// - home input enable and active level
// - clear real counter on home onset
// - home detection halts pulses at once
// - only the home input clears real counter
package apc_pkg;
	localparam int CNT_WIDTH = 32;
	localparam int PER_WIDTH = 16;
	localparam int ADDR_WIDTH = 8;
	localparam int CLK_PERIOD_NS = 8;
	localparam int SCLK_DIV = 2;
	localparam int SCLK_PERIOD_NS = CLK_PERIOD_NS * SCLK_DIV;
	localparam logic [7:0] OFF_CMD = 8'h00;
	localparam logic [7:0] OFF_WR1 = 8'h04;
	localparam logic [7:0] OFF_WR2 = 8'h08;
	localparam logic [7:0] OFF_WR3 = 8'h0c;
	localparam logic [7:0] OFF_PER_INT = 8'h10;
	localparam logic [7:0] OFF_PER_FRAC = 8'h14;
	localparam logic [7:0] OFF_LOGICAL = 8'h18;
	localparam logic [7:0] OFF_REAL = 8'h1c;
	localparam logic [7:0] OFF_UPPER = 8'h20;
	localparam logic [7:0] OFF_LOWER = 8'h24;
	localparam logic [7:0] OFF_STAT1 = 8'h28;
	localparam logic [7:0] OFF_ERR = 8'h2c;
	localparam int CMD_PLUS_BIT = 0;
	localparam int CMD_MINUS_BIT = 1;
	localparam int CMD_DECEL_BIT = 2;
	localparam int CMD_HALT_BIT = 3;
	localparam int WR1_Z_LEVEL_BIT = 4;
	localparam int WR1_Z_EN_BIT = 5;
	localparam int WR1_Z_CLR_BIT = 6;
	localparam int WR2_SLIM_UP_BIT = 0;
	localparam int WR2_SLIM_LOW_BIT = 1;
	localparam int WR2_CMP_SEL_BIT = 5;
	localparam int WR2_ENC_UPDOWN_BIT = 6;
	localparam int WR3_PHASE_LSB = 0;
	localparam int WR3_RING_BIT = 6;
	localparam logic [31:0] WR1_MASK = 32'h0000_0070;
	localparam logic [31:0] WR2_MASK = 32'h0000_0063;
	localparam logic [31:0] WR3_MASK = 32'h0000_0043;
	localparam logic [31:0] WR_RST = 32'h0000_0000;
	localparam logic [31:0] CNT_RST = 32'h0000_0000;
	localparam logic [15:0] PER_INT_RST = 16'h0010;
	localparam logic [15:0] PER_FRAC_RST = 16'h0000;
	localparam logic [16:0] PERIOD_MIN = 17'h00004;
	localparam logic [1:0] PHASE_CONST = 2'b00;
	localparam logic [1:0] PHASE_ACCEL = 2'b01;
	localparam logic [1:0] PHASE_DECEL = 2'b10;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_LOAD = 2'b01,
		S_HIGH = 2'b10,
		S_LOW = 2'b11
	} apc_state_type;
	typedef struct packed {
		logic ring;
		logic [1:0] phase;
		logic enc_updown;
		logic cmp_sel;
		logic slim_low;
		logic slim_up;
		logic z_clr;
		logic z_en;
		logic z_level;
	} apc_cfg_type;
endpackage

// >>> apc_ring_counter.sv
`timescale 1ns/10ps
module apc_ring_counter import apc_pkg::*; #(
	parameter int WIDTH = CNT_WIDTH
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	input wire logic load_i,
	input wire logic [WIDTH-1:0] load_val_i,
	input wire logic clear_i,
	input wire logic inc_i,
	input wire logic dec_i,
	input wire logic ring_en_i,
	input wire logic [WIDTH-1:0] ring_max_i,
	output logic [WIDTH-1:0] count_o
);
	logic [WIDTH-1:0] count_q;
	logic [WIDTH-1:0] count_d;
	wire top_hit = ring_en_i && (count_q == ring_max_i);
	wire zero_hit = count_q == '0;
	wire [WIDTH-1:0] up_val = top_hit ? '0 : count_q + 1'b1;
	wire [WIDTH-1:0] dn_val = (ring_en_i && zero_hit) ? ring_max_i : count_q - 1'b1;
	assign count_d = load_i ? load_val_i : clear_i ? '0 : (inc_i && !dec_i) ? up_val :
		(dec_i && !inc_i) ? dn_val : count_q;
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			count_q <= '0;
		end else if (ce_i) begin
			count_q <= count_d;
		end
	end
	assign count_o = count_q;

	property p_plain_wrap;
		@(posedge clk_i) disable iff (reset_i)
		(ce_i && !load_i && !clear_i && !ring_en_i && inc_i && !dec_i && count_q == '1) |=> count_q == '0;
	endproperty
	a_plain_wrap: assert property (p_plain_wrap) else $error("counter did not wrap to zero");
	property p_ring_wrap;
		@(posedge clk_i) disable iff (reset_i)
		(ce_i && !load_i && !clear_i && ring_en_i && dec_i && !inc_i && zero_hit) |=> count_q == $past(ring_max_i);
	endproperty
	a_ring_wrap: assert property (p_ring_wrap) else $error("ring counter did not wrap to maximum");
endmodule

// >>> apc_drive_model.sv
`timescale 1ns/10ps
module apc_drive_model (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic en_i,
	input wire logic [2:0] lag_i,
	input wire logic updown_i,
	input wire logic pulse_plus_i,
	input wire logic pulse_minus_i,
	output logic enc_a_o,
	output logic enc_b_o
);
	logic [1:0] pos_q;
	logic [1:0] prev_q;
	logic [2:0] wait_q;
	logic dir_q;
	logic busy_q;
	logic up_q;
	logic dn_q;
	// a leads b while moving plus; one strobe per step in up/down mode
	assign enc_a_o = updown_i ? up_q : pos_q[1] ^ pos_q[0];
	assign enc_b_o = updown_i ? dn_q : pos_q[1];
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			pos_q <= 2'h0;
			prev_q <= 2'h0;
			wait_q <= 3'h0;
			dir_q <= 1'h0;
			busy_q <= 1'h0;
			up_q <= 1'h0;
			dn_q <= 1'h0;
		end else begin
			prev_q <= {pulse_plus_i, pulse_minus_i};
			up_q <= busy_q && wait_q == 3'h0 && !dir_q;
			dn_q <= busy_q && wait_q == 3'h0 && dir_q;
			if (busy_q) begin
				wait_q <= wait_q - 3'h1;
				if (wait_q == 3'h0) begin
					busy_q <= 1'h0;
					pos_q <= dir_q ? pos_q - 2'h1 : pos_q + 2'h1;
				end
			end else if (en_i && ((pulse_plus_i && !prev_q[1]) || (pulse_minus_i && !prev_q[0]))) begin
				busy_q <= 1'h1;
				wait_q <= lag_i;
				dir_q <= pulse_minus_i;
			end
		end
	end
endmodule

// >>> testbench.sv
`timescale 1ns/10ps
module testbench import apc_pkg::*;;
	logic clk_i = 0, reset_i = 1, ce_i = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, home_z_input_i = 0, en = 0, ud = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd_q;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [2:0] lag = 0;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp, pp = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, enc_a_i, enc_b_i;
	logic pulse_plus_o, pulse_minus_o, driving_o;
	int n_errors = 0, compares = 0, np = 0, nm = 0, h, l, p, t, s;
	apc_axis_position_control DUT (.clk_i, .reset_i, .ce_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.home_z_input_i, .enc_a_i, .enc_b_i, .pulse_plus_o, .pulse_minus_o, .driving_o);
	apc_drive_model PM (.clk_i, .reset_i, .en_i(en), .lag_i(lag), .updown_i(ud), .pulse_plus_i(pulse_plus_o),
		.pulse_minus_i(pulse_minus_o), .enc_a_o(enc_a_i), .enc_b_o(enc_b_i));
	initial forever #4 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		pp <= {pulse_plus_o, pulse_minus_o};
		if (pulse_plus_o && !pp[1]) np++;
		if (pulse_minus_o && !pp[0]) nm++;
	end
	task automatic chk(input string n, input logic [31:0] v, input logic [31:0] e);
		compares++;
		if (v !== e) begin
			n_errors++;
			$display("[ERR] %s exp %h seen %h", n, e, v);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge clk_i);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 0;
		rsp = s_axi_bresp;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge clk_i);
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 0;
		rd_q = s_axi_rdata;
		rsp = s_axi_rresp;
		@(posedge clk_i);
	endtask
	function automatic logic [31:0] step(logic [31:0] v, int n, logic [31:0] m);
		for (int i = 0; i < (n < 0 ? -n : n); i++)
			v = n > 0 ? (v == m ? 0 : v + 1) : (v == 0 ? m : v - 1);
		return v;
	endfunction
	function automatic int hi_clk(int p, int ph);
		return 2 * (ph == 1 ? p - p / 4 : ph == 2 ? p / 4 : p / 2);
	endfunction
	task automatic wait_clk(int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic meas();
		t = 0;
		h = 0;
		l = 0;
		while (!pulse_plus_o && t < 3000) begin
			@(posedge clk_i);
			t++;
		end
		while (pulse_plus_o && h < 3000) begin
			@(posedge clk_i);
			h++;
		end
		while (!pulse_plus_o && l < 3000) begin
			@(posedge clk_i);
			l++;
		end
	endtask
	task automatic halt_chk(logic [31:0] l0, logic [31:0] r0, logic [31:0] lm, logic [31:0] rm);
		wr(OFF_CMD, 32'h1 << CMD_HALT_BIT);
		wait_clk(20);
		rd(OFF_LOGICAL);
		chk("logical", rd_q, step(l0, np - nm, lm));
		rd(OFF_REAL);
		chk("real", rd_q, step(r0, np - nm, rm));
	endtask
	task automatic finish_test();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		#700000;
		n_errors++;
		finish_test();
	end
	initial begin
		void'($urandom(45145));
		wait_clk(10);
		reset_i <= 0;
		en <= 1;
		@(posedge clk_i);
		rd(OFF_PER_INT);
		chk("per_int", rd_q, 32'h10);
		rd(8'h80);
		chk("rresp", 32'(rsp), 32'(RESP_SLVERR));
		wr(8'h80, 32'h5);
		chk("bresp", 32'(rsp), 32'(RESP_SLVERR));
		$display("test regs done");
		for (int ph = 0; ph < 3; ph++) begin
			p = $urandom_range(40, 4);
			lag <= 3'($urandom_range(4));
			wr(OFF_PER_INT, p);
			wr(OFF_PER_FRAC, 0);
			wr(OFF_WR3, ph);
			wr(OFF_LOGICAL, 32'hffff_fffe);
			wr(OFF_REAL, 32'h1);
			np = 0;
			nm = 0;
			wr(OFF_CMD, 32'h1 << CMD_PLUS_BIT);
			meas();
			meas();
			chk("high", h, hi_clk(p, ph));
			chk("period", h + l, 2 * p);
			halt_chk(32'hffff_fffe, 32'h1, '1, '1);
		end
		$display("test pulse done");
		p = $urandom_range(30, 4);
		s = 0;
		wr(OFF_WR3, 0);
		wr(OFF_PER_INT, p);
		wr(OFF_PER_FRAC, 32'h8000);
		wr(OFF_CMD, 32'h1);
		meas();
		repeat (64) begin
			meas();
			s += h + l;
		end
		chk("average", 32'((s - 128 * p - 64) inside {[-2:2]}), 32'h1);
		wr(OFF_CMD, 32'h1 << CMD_HALT_BIT);
		$display("test fraction done");
		wr(OFF_WR3, 32'h1 << WR3_RING_BIT);
		wr(OFF_UPPER, 3);
		wr(OFF_LOWER, 5);
		for (int d = 0; d < 2; d++) begin
			ud <= (d == 1);
			wr(OFF_WR2, d << WR2_ENC_UPDOWN_BIT);
			wr(OFF_LOGICAL, d ? 0 : 3);
			wr(OFF_REAL, d ? 0 : 5);
			np = 0;
			nm = 0;
			wr(OFF_CMD, 32'h1 << d);
			wait_clk(200);
			wr(OFF_CMD, 32'h1 << CMD_DECEL_BIT);
			wait_clk(80);
			chk("decel", 32'(driving_o), 0);
			halt_chk(d ? 0 : 3, d ? 0 : 5, 3, 5);
		end
		ud <= 0;
		$display("test ring done");
		wr(OFF_WR3, 0);
		for (int i = 0; i < 6; i++) begin
			logic [31:0] u, lo, v;
			u = $urandom;
			lo = $urandom;
			v = i < 2 ? (i ? u : lo) : $urandom;
			wr(OFF_WR2, (i & 1) << WR2_CMP_SEL_BIT);
			wr(OFF_UPPER, u);
			wr(OFF_LOWER, lo);
			wr((i & 1) ? OFF_REAL : OFF_LOGICAL, v);
			rd((i & 1) ? OFF_REAL : OFF_LOGICAL);
			chk("count rw", rd_q, v);
			rd(OFF_STAT1);
			chk("flags", rd_q & 32'h3, 32'({$signed(v) < $signed(lo), $signed(v) > $signed(u)}));
		end
		$display("test compare done");
		wr(OFF_WR2, 32'h3);
		for (int d = 0; d < 2; d++) begin
			wr(OFF_UPPER, 2);
			wr(OFF_LOWER, -2);
			wr(OFF_LOGICAL, 0);
			wr(OFF_CMD, 32'h1 << d);
			t = 0;
			while (driving_o && t < 3000) begin
				@(posedge clk_i);
				t++;
			end
			rd(OFF_ERR);
			chk("limit err", rd_q, 32'h1 << d);
			rd(OFF_LOGICAL);
			chk("limit pos", rd_q, d ? 32'hffff_fffd : 32'h3);
			wr(OFF_LOGICAL, 0);
			rd(OFF_ERR);
			chk("limit clr", rd_q, 0);
		end
		$display("test limit done");
		wr(OFF_WR2, 0);
		en <= 0;
		for (int lv = 0; lv < 2; lv++) begin
			home_z_input_i <= lv == 0;
			wr(OFF_WR1, lv ? 32'h70 : 32'h60);
			wr(OFF_REAL, 32'h1234);
			wr(OFF_CMD, 32'h1);
			wait_clk(40);
			home_z_input_i <= lv == 1;
			wait_clk(3);
			chk("home stop", 32'(driving_o), 0);
			p = np;
			wait_clk(80);
			chk("no pulse", np, p);
			rd(OFF_REAL);
			chk("home clr", rd_q, 0);
		end
		$display("test home done");
		finish_test();
	end
endmodule
